/* File: design/psm_pkg.sv */
package psm_pkg;
   // Register layout
   localparam int REG_W = 4;
   localparam logic [3:0] SBMS_RESET = 4'h8;
   localparam int MODE_BIT = 3;
   localparam int BANK_LSB = 0;
   localparam int BANK_W = 2;
   localparam logic [1:0] BANK_ZERO = 2'h0;
   // Stack frame sizes in bytes
   localparam logic [1:0] FRAME_16K = 2'h2;
   localparam logic [1:0] FRAME_32K = 2'h3;
   // Machine cycles per call kind
   localparam logic [2:0] CYC_LONG_16K = 3'h3;
   localparam logic [2:0] CYC_LONG_32K = 3'h4;
   localparam logic [2:0] CYC_FAR_16K = 3'h2;
   localparam logic [2:0] CYC_FAR_32K = 3'h3;
   // Program counter
   localparam int PC_W = 15;
   localparam int PC_HI_BIT = 14;
   // Call kinds
   typedef enum logic [1:0] {
      PSM_CALL_LONG,
      PSM_CALL_TABLE,
      PSM_CALL_FAR
   } psm_call_t;
endpackage : psm_pkg

/* File: design/psm_call_timer.sv */
`timescale 1ns/1ps
module psm_call_timer (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [2:0] cycles,
   output logic busy,
   output logic done
);
   logic [2:0] count;
   logic [2:0] next_count;
   logic next_busy;
   logic next_done;

   // Counts machine cycles of one call
   always_comb begin
      next_count = count;
      next_busy = busy;
      next_done = 1'b0;
      if (busy) begin
         if (count == 3'h1) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_count = 3'h0;
         end else begin
            next_count = count - 3'h1;
         end
      end else if (start) begin
         next_count = cycles;
         next_busy = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         count <= 3'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         done <= next_done;
      end
   end
endmodule : psm_call_timer

/* File: design/psm_mode_select.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1: A subroutine call pushes a 2-byte frame in 16K mode and a 3-byte frame in 32K mode.
// R2: In 16K mode the stack lives in RAM bank 0; in 32K mode it may be in banks 0 to 3.
// R3: Long and table calls take 3 cycles in 16K mode and 4 in 32K; short far calls take 2 and 3.
// R4: Program counter bit 14 is held at zero in 16K mode and loaded normally in 32K mode.
// R5: The mode comes from the stack bank mode select register.
// R6: That register is written as one 4-bit unit by memory manipulation instructions.
// R7: Reset sets register bit 3 to 1, giving 16K mode with no software write needed.
// R8: Software for 32K mode writes the register with upper bits zero and the bank in the low bits.
// R9: Software for 32K mode makes no call and enables no interrupt before that write.
// R10: The low two register bits pick the stack bank, forced to bank 0 in 16K mode.
module psm_mode_select (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic [3:0] reg_wdata,
   input wire logic call_req,
   input wire psm_pkg::psm_call_t call_kind,
   input wire logic pc_load,
   input wire logic [14:0] pc_target,
   output logic [3:0] stack_bank_mode_select,
   output logic mode_16k,
   output logic [1:0] stack_bank,
   output logic [1:0] frame_bytes,
   output logic [2:0] call_cycles,
   output logic call_busy,
   output logic call_done,
   output logic [14:0] pc
);
   logic [3:0] next_sbms;
   logic next_mode_16k;
   logic [1:0] next_stack_bank;
   logic [1:0] next_frame_bytes;
   logic [2:0] next_call_cycles;
   logic [2:0] req_cycles;
   logic call_accept;
   logic timer_busy;
   logic timer_done;
   logic [14:0] next_pc;

   // Register value after an optional whole-unit write
   function automatic logic [3:0] write_of(input logic [3:0] old, input logic wr, input logic [3:0] data);
      logic [3:0] v;
      v = old;
      if (wr) begin
         v = data; // see R6
      end
      return v;
   endfunction : write_of

   // Mode bit of a register value
   function automatic logic mode_of(input logic [3:0] value);
      logic m;
      m = value[psm_pkg::MODE_BIT];
      return m;
   endfunction : mode_of

   // Stack bank held by a register value
   function automatic logic [1:0] bank_of(input logic [3:0] value);
      logic [1:0] b;
      b = psm_pkg::BANK_ZERO;
      if (mode_of(value)) begin
         b = psm_pkg::BANK_ZERO; // see R2
      end else begin
         b = value[psm_pkg::BANK_LSB +: psm_pkg::BANK_W]; // see R10
      end
      return b;
   endfunction : bank_of

   // Return frame size in bytes
   function automatic logic [1:0] frame_of(input logic m16);
      logic [1:0] f;
      f = psm_pkg::FRAME_32K;
      if (m16) begin
         f = psm_pkg::FRAME_16K; // see R1
      end else begin
         f = psm_pkg::FRAME_32K; // see R1
      end
      return f;
   endfunction : frame_of

   // Machine cycles of one call
   function automatic logic [2:0] cycles_for(input psm_pkg::psm_call_t kind, input logic m16);
      logic [2:0] c;
      c = psm_pkg::CYC_LONG_32K;
      case (kind)
         psm_pkg::PSM_CALL_LONG: begin
            c = m16 ? psm_pkg::CYC_LONG_16K : psm_pkg::CYC_LONG_32K; // see R3
         end
         psm_pkg::PSM_CALL_TABLE: begin
            c = m16 ? psm_pkg::CYC_LONG_16K : psm_pkg::CYC_LONG_32K; // see R3
         end
         psm_pkg::PSM_CALL_FAR: begin
            c = m16 ? psm_pkg::CYC_FAR_16K : psm_pkg::CYC_FAR_32K; // see R3
         end
         default: begin
            c = m16 ? psm_pkg::CYC_LONG_16K : psm_pkg::CYC_LONG_32K; // see R3
         end
      endcase
      return c;
   endfunction : cycles_for

   // Program counter after an optional load
   function automatic logic [14:0] load_of(input logic [14:0] old, input logic ld, input logic [14:0] target);
      logic [14:0] v;
      v = old;
      if (ld) begin
         v = target; // see R4
      end
      return v;
   endfunction : load_of

   // Program counter with bit 14 cleared in 16K mode
   function automatic logic [14:0] pc_fix(input logic [14:0] value, input logic m16);
      logic [14:0] p;
      p = value;
      if (m16) begin
         p[psm_pkg::PC_HI_BIT] = 1'b0; // see R4
      end
      return p;
   endfunction : pc_fix

   // Stack bank mode select register
   always_comb begin
      next_sbms = write_of(stack_bank_mode_select, reg_wr, reg_wdata); // see R6
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stack_bank_mode_select <= psm_pkg::SBMS_RESET; // see R7
      end else begin
         stack_bank_mode_select <= next_sbms;
      end
   end

   // Mode follows the register, same-edge write included
   always_comb begin
      next_mode_16k = mode_of(next_sbms); // see R5
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mode_16k <= mode_of(psm_pkg::SBMS_RESET);
      end else begin
         mode_16k <= next_mode_16k;
      end
   end

   // Stack bank follows the register
   always_comb begin
      next_stack_bank = bank_of(next_sbms); // see R2
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stack_bank <= bank_of(psm_pkg::SBMS_RESET);
      end else begin
         stack_bank <= next_stack_bank;
      end
   end

   // Frame size follows the mode
   always_comb begin
      next_frame_bytes = frame_of(next_mode_16k); // see R1
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         frame_bytes <= frame_of(mode_of(psm_pkg::SBMS_RESET));
      end else begin
         frame_bytes <= next_frame_bytes;
      end
   end

   // Call cycle count
   // Taken from the mode held before any same-edge write, so a call never sees a half-written mode
   assign req_cycles = cycles_for(call_kind, mode_of(stack_bank_mode_select));
   // A request while the timer runs is ignored
   assign call_accept = call_req && !timer_busy;

   always_comb begin
      next_call_cycles = call_cycles;
      if (call_accept) begin
         next_call_cycles = req_cycles; // see R3
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         call_cycles <= 3'h0;
      end else begin
         call_cycles <= next_call_cycles;
      end
   end

   // Call timer
   psm_call_timer u_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .start(call_accept),
      .cycles(req_cycles),
      .busy(timer_busy),
      .done(timer_done)
   );

   // Busy and done come straight from the timer's flops
   assign call_busy = timer_busy;
   assign call_done = timer_done;

   // Program counter, bit 14 follows the mode after any same-edge write
   always_comb begin
      next_pc = load_of(pc, pc_load, pc_target); // see R4
      next_pc = pc_fix(next_pc, next_mode_16k); // see R4
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pc <= 15'h0000;
      end else begin
         pc <= next_pc;
      end
   end
endmodule : psm_mode_select

/* File: tb/psm_mode_select_props.sv */
`timescale 1ns/1ps
module psm_mode_select_props (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic [3:0] reg_wdata,
   input wire logic call_req,
   input wire psm_pkg::psm_call_t call_kind,
   input wire logic pc_load,
   input wire logic [14:0] pc_target,
   input wire logic [3:0] stack_bank_mode_select,
   input wire logic mode_16k,
   input wire logic [1:0] stack_bank,
   input wire logic [1:0] frame_bytes,
   input wire logic [2:0] call_cycles,
   input wire logic call_busy,
   input wire logic call_done,
   input wire logic [14:0] pc
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   a_frame_size: assert property (frame_bytes == (mode_16k ? 2'h2 : 2'h3))
      else $error("bad frame");
   a_stack_bank: assert property (stack_bank == (mode_16k ? 2'h0 : stack_bank_mode_select[1:0]))
      else $error("bad bank");
   a_call_len: assert property (call_req && !call_busy |=> call_busy
      && call_cycles == 3'h2 + $past(call_kind != psm_pkg::PSM_CALL_FAR) + $past(!mode_16k))
      else $error("bad call cycles");
   a_pc_hi_zero: assert property (mode_16k |-> pc[14] == 1'h0)
      else $error("pc bit set");
   a_pc_load: assert property (pc_load |=> pc[13:0] == $past(pc_target[13:0]))
      else $error("bad pc load");
   a_mode_bit: assert property (mode_16k == stack_bank_mode_select[3])
      else $error("bad mode");
   a_reg_write: assert property (reg_wr |=> stack_bank_mode_select == $past(reg_wdata))
      else $error("bad write");
   a_reset_val: assert property ($rose(rst_b) |-> stack_bank_mode_select == 4'h8)
      else $error("bad reset value");
   a_done_after_busy: assert property ($fell(call_busy) |-> call_done)
      else $error("done missing after call");
endmodule : psm_mode_select_props

/* File: tb/psm_mode_select_tb_top.sv */
`timescale 1ns/1ps
module psm_mode_select_tb_top;
   logic sys_clk = 0, rst_b = 0, reg_wr = 0, call_req = 0, pc_load = 0, mode_16k, call_busy, call_done;
   logic [3:0] reg_wdata = 0, stack_bank_mode_select;
   logic [14:0] pc_target = 0, pc;
   logic [1:0] stack_bank, frame_bytes;
   logic [2:0] call_cycles, cnt = 0;
   psm_pkg::psm_call_t call_kind = psm_pkg::PSM_CALL_LONG;
   logic [5:0] q[$];
   int mismatches = 0, n_tests = 0;
   psm_mode_select DUT (.sys_clk, .rst_b, .reg_wr, .reg_wdata, .call_req, .call_kind, .pc_load, .pc_target,
      .stack_bank_mode_select, .mode_16k, .stack_bank, .frame_bytes, .call_cycles, .call_busy, .call_done, .pc);
   task chk(input logic [14:0] seen, input logic [14:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task conclude;
      $display("mismatches %0d checks %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task tick;
      @(posedge sys_clk);
      #1;
   endtask : tick
   initial forever #10 sys_clk = ~sys_clk;
   always @(negedge sys_clk) begin
      if (call_busy === 1'h1) cnt++;
      if (call_done === 1'h1) begin
         chk({cnt, call_cycles}, q.pop_front());
         cnt = 0;
      end
   end
   initial begin
      logic [3:0] w;
      logic [14:0] t;
      logic [2:0] n;
      bit hung;
      void'($urandom(32'h9673));
      hung = 1'b0;
      repeat (12) tick;
      rst_b = 1;
      chk(stack_bank_mode_select, 4'h8);
      for (int i = 0; i < 6 && !hung; i++) begin
         w = {~i[0], ~i[0] & 1'($urandom), 2'($urandom)};
         t = 15'($urandom);
         reg_wr = 1;
         reg_wdata = w;
         pc_load = 1;
         pc_target = t;
         tick;
         reg_wr = 0;
         pc_load = 0;
         chk(stack_bank_mode_select, w);
         chk(mode_16k, w[3]);
         chk(stack_bank, w[3] ? 2'h0 : w[1:0]);
         chk(frame_bytes, w[3] ? 2'h2 : 2'h3);
         chk(pc, {t[14] & ~w[3], t[13:0]});
         for (int k = 0; k < 3 && !hung; k++) begin
            n = 3'h3 - (k == 2) + !w[3];
            q.push_back({n, n});
            call_kind = psm_pkg::psm_call_t'(k);
            call_req = 1;
            tick;
            call_req = 0;
            tick;
            call_req = 1;
            tick;
            call_req = 0;
            for (int j = 0; j < 9 && call_done !== 1'h1; j++) tick;
            if (call_done !== 1'h1) begin
               mismatches++;
               hung = 1'b1;
            end
         end
         $display("test %0d done", i);
      end
      if (!hung) begin
         rst_b = 0;
         repeat (3) tick;
         rst_b = 1;
         chk(stack_bank_mode_select, 4'h8);
         chk(mode_16k, 1'h1);
         chk(stack_bank, 2'h0);
         chk(frame_bytes, 2'h2);
         chk(call_cycles, 3'h0);
         chk(pc, 15'h0000);
         $display("test reset done");
      end
      tick;
      conclude;
   end
endmodule : psm_mode_select_tb_top
bind psm_mode_select psm_mode_select_props CHK (.sys_clk, .rst_b, .reg_wr, .reg_wdata, .call_req, .call_kind,
   .pc_load, .pc_target, .stack_bank_mode_select, .mode_16k, .stack_bank, .frame_bytes, .call_cycles, .call_busy,
   .call_done, .pc);
